// [rtl/ctti_cond_eval.v]
/*
 * Combinational evaluator of the 4-bit condition field against the
 * condition code flags.
 * Assumes flags and field come from registers on the same clock.
 */
`timescale 1ns/1ps
`include "ctti_regs.vh"

module ctti_cond_eval (
  input  wire [3:0] cond,
  input  wire       flag_n,
  input  wire       flag_z,
  input  wire       flag_v,
  input  wire       flag_c,
  output reg        cond_true
);

  // ****************************************************************
  // Sixteen tests, one per encoding
  // ****************************************************************
  always @* begin
    case (cond)
      `CTTI_CC_TRUE:      cond_true = 1'b1;
      `CTTI_CC_FALSE:     cond_true = 1'b0;
      `CTTI_CC_HIGH:      cond_true = ~flag_c & ~flag_z;
      `CTTI_CC_LOW_SAME:  cond_true = flag_c | flag_z;
      `CTTI_CC_CARRY_CLR: cond_true = ~flag_c;
      `CTTI_CC_CARRY_SET: cond_true = flag_c;
      `CTTI_CC_NOT_EQUAL: cond_true = ~flag_z;
      `CTTI_CC_ZERO_SET:  cond_true = flag_z;
      `CTTI_CC_OVF_CLR:   cond_true = ~flag_v;
      `CTTI_CC_OVF_SET:   cond_true = flag_v;
      `CTTI_CC_PLUS:      cond_true = ~flag_n;
      `CTTI_CC_MINUS:     cond_true = flag_n;
      `CTTI_CC_GE:        cond_true = ~(flag_n ^ flag_v);
      `CTTI_CC_LT:        cond_true = flag_n ^ flag_v;
      `CTTI_CC_GT:        cond_true = ~flag_z & ~(flag_n ^ flag_v);
      default:            cond_true = flag_z | (flag_n ^ flag_v);
    endcase
  end

endmodule

// [rtl/ctti_regs.vh]
/*
 * Register map, field positions, encodings and reset values for the
 * condition test and table interpolation slice.
 * Assumes inclusion by bare name from the design files under rtl/.
 */
`ifndef CTTI_REGS_VH
`define CTTI_REGS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define CTTI_ADDR_CTRL      8'h00
`define CTTI_ADDR_CCR       8'h04
`define CTTI_ADDR_OPERAND   8'h08
`define CTTI_ADDR_ENTRY_LO  8'h0c
`define CTTI_ADDR_ENTRY_HI  8'h10
`define CTTI_ADDR_RESULT    8'h14
`define CTTI_ADDR_STATUS    8'h18

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTTI_CTRL_START     0
`define CTTI_CTRL_OP_LO     1
`define CTTI_CTRL_OP_HI     2
`define CTTI_CTRL_SIZE_LO   3
`define CTTI_CTRL_SIZE_HI   4
`define CTTI_CTRL_SRC       5
`define CTTI_CTRL_COND_LO   8
`define CTTI_CTRL_COND_HI   11
`define CTTI_CTRL_BRANCH    12
`define CTTI_CTRL_MASK      32'h00001f3e
`define CTTI_CTRL_RESET     32'h00000000

// ****************************************************************
// Condition code register fields
// ****************************************************************
`define CTTI_CCR_C          0
`define CTTI_CCR_V          1
`define CTTI_CCR_Z          2
`define CTTI_CCR_N          3
`define CTTI_CCR_X          4
`define CTTI_CCR_MASK       32'h0000001f
`define CTTI_CCR_RESET      32'h00000000

// ****************************************************************
// Status register fields
// ****************************************************************
`define CTTI_STAT_TRUE      0
`define CTTI_STAT_ILLEGAL   1
`define CTTI_STAT_DONE      2
`define CTTI_STAT_OFS_LO    8
`define CTTI_STAT_OFS_HI    15

// ****************************************************************
// Operand fields: entry offset and fraction
// ****************************************************************
`define CTTI_OPND_OFS_LO    8
`define CTTI_OPND_OFS_HI    15
`define CTTI_OPND_FRAC_LO   0
`define CTTI_OPND_FRAC_HI   7
`define CTTI_FRAC_BITS      8

// ****************************************************************
// Encodings
// ****************************************************************
`define CTTI_OP_SIGNED_ROUNDED      2'h0
`define CTTI_OP_SIGNED_UNROUNDED    2'h1
`define CTTI_OP_UNSIGNED_ROUNDED    2'h2
`define CTTI_OP_UNSIGNED_UNROUNDED  2'h3
`define CTTI_SIZE_BYTE      2'h0
`define CTTI_SIZE_WORD      2'h1
`define CTTI_SIZE_LONG      2'h2
`define CTTI_MASK_BYTE      32'h000000ff
`define CTTI_MASK_WORD      32'h0000ffff
`define CTTI_MASK_UBYTE     32'h0000ffff
`define CTTI_MASK_UWORD     32'h00ffffff
`define CTTI_MASK_LONG      32'hffffffff

`define CTTI_CC_TRUE        4'h0
`define CTTI_CC_FALSE       4'h1
`define CTTI_CC_HIGH        4'h2
`define CTTI_CC_LOW_SAME    4'h3
`define CTTI_CC_CARRY_CLR   4'h4
`define CTTI_CC_CARRY_SET   4'h5
`define CTTI_CC_NOT_EQUAL   4'h6
`define CTTI_CC_ZERO_SET    4'h7
`define CTTI_CC_OVF_CLR     4'h8
`define CTTI_CC_OVF_SET     4'h9
`define CTTI_CC_PLUS        4'ha
`define CTTI_CC_MINUS       4'hb
`define CTTI_CC_GE          4'hc
`define CTTI_CC_LT          4'hd
`define CTTI_CC_GT          4'he
`define CTTI_CC_LE          4'hf

`define CTTI_RESP_OKAY      2'h0
`define CTTI_RESP_SLVERR    2'h2

`endif

// [rtl/ctti_top.v]
/*
 * Condition test and table interpolation slice behind an AXI4-Lite slave.
 * Software loads flags, condition, operand and the two bracketing entries,
 * then starts an interpolation; result and test outcome read back.
 * Assumes a single 125 MHz clock and a synchronous active-low reset.
 */
// Our own choices: the AXI4-Lite slave port and the register offsets.
// Notes on behaviour
// - A condition test is true when its flag expression is one and false when it is zero.
// - A 4-bit condition field selects one of sixteen tests, shared by branches and the conditional trap.
// - Code 0000 is always true and code 0001 always false whatever the flags.
// - The always-false code is flagged invalid when used by a conditional branch, but allowed elsewhere.
// - The zero_set_test, code 0111, is true only when the zero flag is set.
// - Signed interpolation comes rounded or unrounded in byte, word or long size.
// - Unsigned interpolation comes rounded or unrounded in byte, word or long size.
// - Every variant accepts a memory-table entry pair or a data-register pair for surface interpolation.
// - In table form the entry offset is operand bits 15 to 8 and the fraction bits 7 to 0.
// - The result is the entry plus fraction times the difference to the next entry, over 256.
// - The 8-bit fraction gives 256 levels between entries, so a full table has 257 entries.
// - Unrounded variants keep the fractional part of the result.
// - Rounded variants round to nearest, ties to even.
`timescale 1ns/1ps
`include "ctti_regs.vh"

module ctti_top #(
  parameter ADDR_W = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output reg               cond_true_out
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [31:0]       ctrl;
  reg  [31:0]       condition_code_register;
  reg  [31:0]       independent_operand_register;
  reg  [31:0]       entry_lo;
  reg  [31:0]       entry_hi;
  reg  [31:0]       result;
  reg               done;
  reg               start;
  reg               cond_illegal;
  reg  [ADDR_W-1:0] aw_addr;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;

  wire              cond_true;
  wire [3:0]        cond_field;
  wire [1:0]        op_sel;
  wire [1:0]        size_sel;
  wire              wr_go;
  wire              wr_map;
  wire [31:0]       wmask;

  assign cond_field = ctrl[`CTTI_CTRL_COND_HI:`CTTI_CTRL_COND_LO];
  assign op_sel     = ctrl[`CTTI_CTRL_OP_HI:`CTTI_CTRL_OP_LO];
  assign size_sel   = ctrl[`CTTI_CTRL_SIZE_HI:`CTTI_CTRL_SIZE_LO];
  assign wmask      = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  // ****************************************************************
  // Condition test
  // ****************************************************************
  ctti_cond_eval u_cond (
    .cond      (cond_field),
    .flag_n    (condition_code_register[`CTTI_CCR_N]),
    .flag_z    (condition_code_register[`CTTI_CCR_Z]),
    .flag_v    (condition_code_register[`CTTI_CCR_V]),
    .flag_c    (condition_code_register[`CTTI_CCR_C]),
    .cond_true (cond_true)
  );

  always @(posedge aclk) begin
    if (!aresetn) begin
      cond_true_out <= 1'b0;
      cond_illegal  <= 1'b0;
    end else begin
      cond_true_out <= cond_true;
      // Branch use of never-true is reported, trap use is not
      cond_illegal  <= ctrl[`CTTI_CTRL_BRANCH] & (cond_field == `CTTI_CC_FALSE);
    end
  end

  // ****************************************************************
  // Interpolation datapath
  // ****************************************************************
  // Entries extended to 34 bits so unsigned long entries stay positive
  function [33:0] extend;
    input [31:0] d;
    input [1:0]  sz;
    input        sgn;
    begin
      if (sz == `CTTI_SIZE_BYTE)
        extend = {{26{sgn & d[7]}}, d[7:0]};
      else if (sz == `CTTI_SIZE_WORD)
        extend = {{18{sgn & d[15]}}, d[15:0]};
      else
        extend = {{2{sgn & d[31]}}, d};
    end
  endfunction

  wire               is_signed;
  wire               is_rounded;
  wire [7:0]         frac;
  wire signed [33:0] e0;
  wire signed [33:0] e1;
  wire signed [34:0] diff;
  wire signed [43:0] prod;
  wire signed [43:0] full;
  wire [35:0]        quot;
  wire [7:0]         rem;
  wire               round_up;
  wire [35:0]        quot_rnd;
  reg  [31:0]        next_result;

  assign is_signed  = (op_sel == `CTTI_OP_SIGNED_ROUNDED) | (op_sel == `CTTI_OP_SIGNED_UNROUNDED);
  assign is_rounded = (op_sel == `CTTI_OP_SIGNED_ROUNDED) | (op_sel == `CTTI_OP_UNSIGNED_ROUNDED);
  // Fraction always from the low operand byte; pair form uses the same field
  assign frac = independent_operand_register[`CTTI_OPND_FRAC_HI:`CTTI_OPND_FRAC_LO];
  // Lower entry is the selected one from the table or first register of the pair
  assign e0   = $signed(extend(entry_lo, size_sel, is_signed));
  assign e1   = $signed(extend(entry_hi, size_sel, is_signed));
  assign diff = {e1[33], e1} - {e0[33], e0};
  assign prod = diff * $signed({1'b0, frac});
  // Scaled by 256: the low byte holds the fraction of the result
  assign full = {{2{e0[33]}}, e0, {`CTTI_FRAC_BITS{1'b0}}} + prod;
  assign quot = full[43:8];
  assign rem  = full[7:0];
  // Floor quotient plus ties-to-even gives correct rounding for negatives too
  assign round_up = rem[7] & ((|rem[6:0]) | quot[0]);
  assign quot_rnd = quot + {35'h0, round_up};

  always @* begin
    next_result = result;
    if (is_rounded) begin
      if (size_sel == `CTTI_SIZE_BYTE)
        next_result = quot_rnd[31:0] & `CTTI_MASK_BYTE;
      else if (size_sel == `CTTI_SIZE_WORD)
        next_result = quot_rnd[31:0] & `CTTI_MASK_WORD;
      else
        next_result = quot_rnd[31:0] & `CTTI_MASK_LONG;
    end else begin
      // Keep one fraction byte above the result width; long loses top byte
      if (size_sel == `CTTI_SIZE_BYTE)
        next_result = full[31:0] & `CTTI_MASK_UBYTE;
      else if (size_sel == `CTTI_SIZE_WORD)
        next_result = full[31:0] & `CTTI_MASK_UWORD;
      else
        next_result = full[31:0] & `CTTI_MASK_LONG;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      result <= 32'h00000000;
      done   <= 1'b0;
    end else begin
      if (start) begin
        result <= next_result;
        done   <= 1'b1;
      end else if (wr_go && wr_map && aw_addr == `CTTI_ADDR_CTRL) begin
        done   <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  // Address and data held until both are present; one write in flight
  assign wr_go  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign wr_map = (aw_addr == `CTTI_ADDR_CTRL) | (aw_addr == `CTTI_ADDR_CCR) |
                  (aw_addr == `CTTI_ADDR_OPERAND) | (aw_addr == `CTTI_ADDR_ENTRY_LO) |
                  (aw_addr == `CTTI_ADDR_ENTRY_HI);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CTTI_RESP_OKAY;
      aw_addr       <= {ADDR_W{1'b0}};
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `CTTI_RESP_OKAY : `CTTI_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl                         <= `CTTI_CTRL_RESET;
      condition_code_register      <= `CTTI_CCR_RESET;
      independent_operand_register <= 32'h00000000;
      entry_lo                     <= 32'h00000000;
      entry_hi                     <= 32'h00000000;
      start                        <= 1'b0;
    end else begin
      start <= 1'b0;
      if (wr_go) begin
        if (aw_addr == `CTTI_ADDR_CTRL) begin
          ctrl  <= ((ctrl & ~wmask) | (w_data & wmask)) & `CTTI_CTRL_MASK;
          // Start is a pulse; it never reads back as set
          start <= w_strb[0] & w_data[`CTTI_CTRL_START];
        end else if (aw_addr == `CTTI_ADDR_CCR) begin
          condition_code_register <= ((condition_code_register & ~wmask) | (w_data & wmask)) & `CTTI_CCR_MASK;
        end else if (aw_addr == `CTTI_ADDR_OPERAND) begin
          independent_operand_register <= (independent_operand_register & ~wmask) | (w_data & wmask);
        end else if (aw_addr == `CTTI_ADDR_ENTRY_LO) begin
          entry_lo <= (entry_lo & ~wmask) | (w_data & wmask);
        end else if (aw_addr == `CTTI_ADDR_ENTRY_HI) begin
          entry_hi <= (entry_hi & ~wmask) | (w_data & wmask);
        end
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  reg [31:0] rd_mux;
  reg        rd_map;

  always @* begin
    rd_mux = 32'h00000000;
    rd_map = 1'b1;
    if (s_axi_araddr == `CTTI_ADDR_CTRL) begin
      rd_mux = ctrl;
    end else if (s_axi_araddr == `CTTI_ADDR_CCR) begin
      rd_mux = condition_code_register;
    end else if (s_axi_araddr == `CTTI_ADDR_OPERAND) begin
      rd_mux = independent_operand_register;
    end else if (s_axi_araddr == `CTTI_ADDR_ENTRY_LO) begin
      rd_mux = entry_lo;
    end else if (s_axi_araddr == `CTTI_ADDR_ENTRY_HI) begin
      rd_mux = entry_hi;
    end else if (s_axi_araddr == `CTTI_ADDR_RESULT) begin
      rd_mux = result;
    end else if (s_axi_araddr == `CTTI_ADDR_STATUS) begin
      rd_mux[`CTTI_STAT_TRUE]    = cond_true_out;
      rd_mux[`CTTI_STAT_ILLEGAL] = cond_illegal;
      rd_mux[`CTTI_STAT_DONE]    = done;
      // Entry offset shown so software can fetch the bracketing entries
      rd_mux[`CTTI_STAT_OFS_HI:`CTTI_STAT_OFS_LO] =
        independent_operand_register[`CTTI_OPND_OFS_HI:`CTTI_OPND_OFS_LO];
    end else begin
      rd_map = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `CTTI_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= rd_map ? `CTTI_RESP_OKAY : `CTTI_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// [verif/ctti_top_chk.sv]
/*
 * Port-level checker for ctti_top: bus answers, error responses and fixed condition outcomes.
 * Assumes the tb writes with address and data offered together and all strobes set.
 */
`timescale 1ns/1ps

module ctti_top_chk #(
  parameter ADDR_W = 8
) (
  input wire              aclk,
  input wire              aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire [31:0]       s_axi_wdata,
  input wire [3:0]        s_axi_wstrb,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire [1:0]        s_axi_bresp,
  input wire              s_axi_bvalid,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire [1:0]        s_axi_rresp,
  input wire              s_axi_rvalid,
  input wire              s_axi_rready,
  input wire              cond_true_out
);
  // ****************************************************************
  // Handshake helpers
  // ****************************************************************
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar_go = s_axi_arvalid && s_axi_arready;
  // Condition byte lane must be written, else the old field stays
  wire cc_wr = wr_go && s_axi_awaddr == 8'h00 && s_axi_wstrb[1];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Write executes the edge after the take, so the answer is seen one edge later
  chk_b_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_w_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  chk_r_answer: assert property (ar_go |=> s_axi_rvalid)
    else $error("read response late");
  chk_r_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  chk_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not released");
  chk_rd_unmapped: assert property (ar_go && s_axi_araddr > 8'h18 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_wr_readonly: assert property (wr_go && s_axi_awaddr >= 8'h14 |-> ##2 s_axi_bresp == 2'h2)
    else $error("read-only write not refused");
  chk_wr_okay: assert property (wr_go && s_axi_awaddr < 8'h14 |-> ##2 s_axi_bresp == 2'h0)
    else $error("mapped write refused");
  // Take, register write, then the outcome flop: three edges
  chk_cond_always: assert property (cc_wr && s_axi_wdata[11:8] == 4'h0 |-> ##3 cond_true_out)
    else $error("always-true code not true");
  chk_cond_never: assert property (cc_wr && s_axi_wdata[11:8] == 4'h1 |-> ##3 !cond_true_out)
    else $error("always-false code not false");

  cov_write: cover property (wr_go ##2 s_axi_bvalid);
  cov_rd_err: cover property (ar_go && s_axi_araddr > 8'h18);
  cov_false: cover property (cc_wr && s_axi_wdata[11:8] == 4'h1);
endmodule

// [verif/ctti_top_tb.sv]
/*
 * Self-checking bench for ctti_top: condition tests, interpolation variants, bus errors.
 * Assumes ctti_top and ctti_regs.vh from rtl/ and the checker from verif/.
 */
`timescale 1ns/1ps
`include "ctti_regs.vh"

module ctti_top_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cond_true_out;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          fail_count, tests_run;
  // Row: control without start, first entry, next entry, operand, expected result
  logic [31:0] tv [11][5] = '{
    '{32'h08, 32'h685, 32'h68f, 32'ha380, 32'h68a}, '{32'h0a, 32'h685, 32'h68f, 32'ha380, 32'h68a00},
    '{32'h00, 32'h0, 32'h1, 32'h0080, 32'h0}, '{32'h00, 32'h1, 32'h2, 32'h0080, 32'h2},
    '{32'h00, 32'h80, 32'h7f, 32'h0040, 32'hc0}, '{32'h04, 32'h0, 32'hff, 32'h0080, 32'h80},
    '{32'h06, 32'h0, 32'hff, 32'h0080, 32'h7f80}, '{32'h02, 32'h80, 32'h7f, 32'h0040, 32'hbfc0},
    '{32'h34, 32'h10000, 32'h10100, 32'h0010, 32'h10010}, '{32'h30, 32'hffffff00, 32'h100, 32'h00ff, 32'hfe},
    '{32'h0c, 32'h1234, 32'h5678, 32'hff00, 32'h1234}};

  ctti_top #(.ADDR_W(8)) ctti_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cond_true_out);

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    chk32({31'h0, s_axi_bvalid}, 32'h1, "bvalid timeout");
    chk32({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    s_axi_rready <= 1'b0;
    chk32({31'h0, s_axi_rvalid}, 32'h1, "rvalid timeout");
    d = s_axi_rdata;
    chk32({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
  endtask

  // Pairs share a test and differ only in sense, so odd codes invert
  function automatic logic exp_cc(input logic [3:0] c, input logic [3:0] f);
    logic b;
    case (c[3:1])
      3'h0: b = 1'b1;
      3'h1: b = !f[0] && !f[2];
      3'h2: b = !f[0];
      3'h3: b = !f[2];
      3'h4: b = !f[1];
      3'h5: b = !f[3];
      3'h6: b = f[3] == f[1];
      default: b = !f[2] && (f[3] == f[1]);
    endcase
    return b ^ c[0];
  endfunction

  task automatic wrap_up;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    @(posedge aclk);
    #1;
    chk32({31'h0, cond_true_out}, 32'h1, "cond after reset");
    rd(`CTTI_ADDR_CTRL, 2'h0, rv);
    chk32(rv, `CTTI_CTRL_RESET, "ctrl reset");
    rd(`CTTI_ADDR_CCR, 2'h0, rv);
    chk32(rv, `CTTI_CCR_RESET, "ccr reset");
    rd(`CTTI_ADDR_STATUS, 2'h0, rv);
    chk32(rv, 32'h1, "status reset");
    $display("t_reset done");
  endtask

  task automatic t_cond;
    for (int f = 0; f < 16; f++) begin
      wr(`CTTI_ADDR_CCR, f | (f[0] ? 32'h10 : 32'h0), 2'h0);
      for (int c = 0; c < 16; c++) begin
        wr(`CTTI_ADDR_CTRL, c << 8, 2'h0);
        @(posedge aclk);
        #1;
        chk32({31'h0, cond_true_out}, {31'h0, exp_cc(c, f)}, "cond");
      end
    end
    $display("t_cond done");
  endtask

  task automatic t_branch;
    logic [31:0] ctl [3] = '{32'h1100, 32'h0100, 32'h1000};
    logic [31:0] st [3] = '{32'h2, 32'h0, 32'h1};
    for (int i = 0; i < 3; i++) begin
      wr(`CTTI_ADDR_CTRL, ctl[i], 2'h0);
      rd(`CTTI_ADDR_STATUS, 2'h0, rv);
      chk32(rv & 32'h3, st[i], "branch status");
    end
    $display("t_branch done");
  endtask

  task automatic t_interp;
    for (int i = 0; i < 11; i++) begin
      wr(`CTTI_ADDR_OPERAND, tv[i][3], 2'h0);
      wr(`CTTI_ADDR_ENTRY_LO, tv[i][1], 2'h0);
      wr(`CTTI_ADDR_ENTRY_HI, tv[i][2], 2'h0);
      wr(`CTTI_ADDR_CTRL, tv[i][0] | 32'h1, 2'h0);
      rd(`CTTI_ADDR_RESULT, 2'h0, rv);
      chk32(rv, tv[i][4], "result");
      rd(`CTTI_ADDR_STATUS, 2'h0, rv);
      chk32(rv & 32'hff07, {16'h0, tv[i][3][15:8], 8'h05}, "status");
    end
    wr(`CTTI_ADDR_CTRL, 32'h0, 2'h0);
    rd(`CTTI_ADDR_STATUS, 2'h0, rv);
    chk32(rv & 32'h4, 32'h0, "done clear");
    $display("t_interp done");
  endtask

  task automatic t_bus;
    wr(`CTTI_ADDR_RESULT, 32'h5a5a5a5a, 2'h2);
    wr(`CTTI_ADDR_STATUS, 32'h5a5a5a5a, 2'h2);
    wr(8'h1c, 32'h5a5a5a5a, 2'h2);
    rd(`CTTI_ADDR_RESULT, 2'h0, rv);
    chk32(rv, 32'h1234, "result kept");
    rd(8'h1c, 2'h2, rv);
    chk32(rv, 32'h0, "unmapped data");
    rd(8'hfc, 2'h2, rv);
    wr(`CTTI_ADDR_CCR, 32'hffffffff, 2'h0);
    rd(`CTTI_ADDR_CCR, 2'h0, rv);
    chk32(rv, `CTTI_CCR_MASK, "ccr bits");
    wr(`CTTI_ADDR_CTRL, 32'hffffffff, 2'h0);
    rd(`CTTI_ADDR_CTRL, 2'h0, rv);
    chk32(rv, `CTTI_CTRL_MASK, "ctrl bits");
    $display("t_bus done");
  endtask

  // ****************************************************************
  // Clock, sequence and watchdog
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 54'h0;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_cond;
    t_branch;
    t_interp;
    t_bus;
    wrap_up;
  end

  // Whole run is under two thousand cycles; this allows ample margin
  initial begin
    #400000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule

bind ctti_top ctti_top_chk #(.ADDR_W(ADDR_W)) ctti_top_chk_inst (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .cond_true_out);
